// >>> inc/adc_port_pkg.sv
// Shared constants, field layout and state types of the converter host port
package adc_port_pkg;
	// Register bus offsets, byte addresses
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_CONFIG = 8'h0c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Status and control word fields
	localparam int STAT_RDY_BIT = 0;
	localparam int STAT_STATE_LSB = 1;
	localparam int STAT_LEVEL_LSB = 4;
	localparam int STAT_CS_BIT = 8;
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RST = 1'h1;
	// Serial register select codes
	localparam logic [2:0] RS_COMM = 3'h0;
	localparam logic [2:0] RS_SETUP = 3'h1;
	localparam logic [2:0] RS_CLOCK = 3'h2;
	localparam logic [2:0] RS_DATA = 3'h3;
	localparam logic [2:0] RS_TEST = 3'h4;
	localparam logic [2:0] RS_ZCAL = 3'h6;
	localparam logic [2:0] RS_FCAL = 3'h7;
	// Communication byte fields
	localparam int COMM_START_BIT = 7;
	localparam int COMM_RS_LSB = 4;
	localparam int COMM_RD_BIT = 3;
	// Setting register fields
	localparam int SET_MODE_LSB = 6;
	localparam int SET_GAIN_LSB = 3;
	localparam int SET_UNI_BIT = 2;
	// Clock register fields
	localparam int CLK_DIS_BIT = 4;
	localparam int CLK_RATE_LSB = 0;
	// Register widths in serial bits
	localparam int SHIFT_W = 24;
	localparam logic [4:0] W_BYTE = 5'h08;
	localparam logic [4:0] W_DATA = 5'h10;
	localparam logic [4:0] W_CAL = 5'h18;
	// Reset values
	localparam logic [7:0] COMM_RST = 8'h00;
	localparam logic [7:0] SETUP_RST = 8'h00;
	localparam logic [7:0] CLOCK_RST = 8'h00;
	localparam logic [7:0] TEST_RST = 8'h00;
	localparam logic [23:0] ZCAL_RST = 24'h000000;
	localparam logic [23:0] FCAL_RST = 24'h800000;
	// Calibration modes held in the setting register
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_SELF = 2'h1;
	localparam logic [1:0] MODE_SYS_ZERO = 2'h2;
	localparam logic [1:0] MODE_SYS_FULL = 2'h3;
	// Data-ready high time between unread updates, in master clock periods
	localparam int HOLD_MCLK = 500;
	localparam int FIFO_DEPTH = 8;
	localparam int RES_W = 16;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_READY = 2'b01, ST_HOLD = 2'b10, ST_CAL = 2'b11} main_state_t;
	typedef enum logic [1:0] {SER_CMD = 2'b00, SER_WR = 2'b01, SER_RD = 2'b10} ser_state_t;
endpackage

// >>> sim/host_model.sv
// Host controller model for the serial side of the converter port
`timescale 1ns/1ps
module host_model (
	// Serial pins
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout
);
	localparam time HALF = 24ns;
	// Idle frame: clock parked high, not selected
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b1;
	end
	// Command byte then n bits MSB first, clock idle high, select held low
	task automatic frame(input logic [7:0] cmd, input int n, input logic [23:0] wr, output logic [23:0] rd);
		logic [31:0] sh;
		sh = {cmd, wr << (24 - n)};
		rd = '0;
		#1;
		cs_n = 1'b0;
		#(2*HALF);
		for (int i = 0; i < 8 + n; i++) begin
			sclk = 1'b0;
			din = sh[31];
			#HALF;
			if (i >= 8) rd = {rd[22:0], dout};
			sclk = 1'b1;
			sh = sh << 1;
			#HALF;
		end
		cs_n = 1'b1;
		din = ~din; // No stale value once released
		#(4*HALF);
	endtask
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the converter host port
`timescale 1ns/1ps
module tb_top;
	import adc_port_pkg::*;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] rs; logic [31:0] rv;} row_t;
	localparam int HOLD = 4;
	logic clk, srst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr, gain_factor;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs, cal_mode, rate_sel;
	logic sclk, cs_n, din, dout, dout_oe, result_ready_n, mclk_in, mclk_out, mclk_out_oe, reset_n;
	logic [15:0] res_data;
	logic res_valid, res_ready, cal_start, cal_done, unipolar;
	logic [23:0] cal_value, sd;
	int failures, checks, cnt, cal_seen;
	row_t rows [7];
	// Device under test with a short hold count
	adc_port #(.HOLD_COUNT(HOLD), .DEPTH(FIFO_DEPTH)) dut_u (.clk(clk), .srst(srst), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout), .dout_oe(dout_oe), .result_ready_n(result_ready_n), .mclk_in(mclk_in),
		.mclk_out(mclk_out), .mclk_out_oe(mclk_out_oe), .reset_n(reset_n), .res_data(res_data),
		.res_valid(res_valid), .res_ready(res_ready), .cal_start(cal_start), .cal_mode(cal_mode),
		.cal_done(cal_done), .cal_value(cal_value), .gain_factor(gain_factor), .unipolar(unipolar),
		.rate_sel(rate_sel));
	// Serial host partner
	host_model host_u (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
	// Clocks: system and external master clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		mclk_in = 1'b0;
		forever #53 mclk_in = ~mclk_in;
	end
	// Calibration start pulses seen
	always @(posedge clk) if (cal_start === 1'b1) cal_seen <= cal_seen + 1;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Bus write: address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (!aw && awready === 1'b1) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic wait_rdy(input logic v);
		cnt = 0;
		while (result_ready_n !== v && cnt < 4000) begin
			@(posedge clk);
			cnt++;
		end
		chk("result_ready_n", v, result_ready_n);
	endtask
	task automatic push(input logic [15:0] v);
		@(posedge clk);
		res_data <= v;
		res_valid <= 1'b1;
		do @(posedge clk); while (res_ready !== 1'b1);
		res_valid <= 1'b0;
	endtask
	// Read one result only once data-ready is low
	task automatic read_res(input logic [15:0] e);
		wait_rdy(1'b0);
		host_u.frame(8'h38, 16, 24'h0, sd);
		chk("result", e, sd[15:0]);
	endtask
	// Main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, res_valid, cal_done, reset_n} = '0;
		{awaddr, araddr, wdata, res_data, cal_value} = '0;
		wstrb = 4'hf;
		failures = 0;
		checks = 0;
		cal_seen = 0;
		srst = 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		reset_n <= 1'b1;
		repeat (10) @(posedge clk);
		chk("dout_oe idle", 0, dout_oe);
		rows = '{'{1'b0, OFF_STATUS, 0, RESP_OKAY, 32'h1}, '{1'b0, OFF_CTRL, 0, RESP_OKAY, 32'h1},
			'{1'b1, OFF_CTRL, 0, RESP_OKAY, 0}, '{1'b0, OFF_CTRL, 0, RESP_OKAY, 0},
			'{1'b1, 8'h10, 32'h1, RESP_SLVERR, 0}, '{1'b0, 8'h10, 0, RESP_SLVERR, 0},
			'{1'b0, OFF_CONFIG, 0, RESP_OKAY, 0}};
		foreach (rows[i]) begin
			if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, rs);
			else axi_rd(rows[i].a, rv, rs);
			chk("resp", rows[i].rs, rs);
			if (!rows[i].wr) chk("rdata", rows[i].rv, rv);
		end
		for (int g = 0; g < 8; g++) begin
			host_u.frame(8'h10, 8, 24'(g << SET_GAIN_LSB), sd);
			chk("gain_factor", 8'h01 << g, gain_factor);
		end
		host_u.frame(8'h20, 8, 24'h03, sd);
		chk("rate_sel", 2'h3, rate_sel);
		@(posedge mclk_in);
		repeat (8) @(posedge clk);
		chk("mclk_out high phase", 0, mclk_out);
		@(negedge mclk_in);
		repeat (8) @(posedge clk);
		chk("mclk_out low phase", 1, mclk_out);
		chk("mclk_out_oe on", 1, mclk_out_oe);
		host_u.frame(8'h20, 8, 24'h10, sd);
		chk("mclk_out_oe", 0, mclk_out_oe);
		chk("mclk_out", 0, mclk_out);
		host_u.frame(8'h20, 8, 24'h00, sd);
		// Fill the result buffer while updates are disabled
		cnt = 0;
		@(posedge clk);
		res_valid <= 1'b1;
		res_data <= 16'h0100;
		for (int i = 0; i < 20 && res_ready !== 1'b0; i++) begin
			@(posedge clk);
			if (res_ready === 1'b1) begin
				cnt++;
				res_data <= 16'h0100 + 16'(cnt);
			end
		end
		res_valid <= 1'b0;
		chk("fifo accepted", FIFO_DEPTH, cnt);
		axi_rd(OFF_STATUS, rv, rs);
		chk("fifo level", FIFO_DEPTH, rv[7:4]);
		axi_wr(OFF_CTRL, 32'h1, rs);
		for (int i = 0; i < FIFO_DEPTH; i++) read_res(16'h8100 + 16'(i));
		wait_rdy(1'b1);
		// Unread result replaced after the hold time
		push(16'h0011);
		wait_rdy(1'b0);
		push(16'h0022);
		wait_rdy(1'b1);
		cnt = 0;
		while (result_ready_n === 1'b1 && cnt < 50) begin
			@(posedge mclk_in);
			cnt++;
		end
		chk("hold length", 1, cnt >= HOLD - 1 && cnt <= HOLD + 1);
		read_res(16'h8022);
		// Output coding for both polarities
		host_u.frame(8'h10, 8, 24'h04, sd);
		chk("unipolar", 1, unipolar);
		push(16'h1234);
		read_res(16'h2468);
		push(16'h8000);
		read_res(16'h0000);
		host_u.frame(8'h10, 8, 24'h00, sd);
		push(16'h7fff);
		read_res(16'hffff);
		// Calibration modes end with data-ready low
		for (int m = 1; m < 4; m++) begin
			cnt = cal_seen;
			host_u.frame(8'h10, 8, 24'(m << SET_MODE_LSB), sd);
			chk("cal_start", cnt + 1, cal_seen);
			chk("cal_mode", m, cal_mode);
			chk("ready during cal", 1, result_ready_n);
			@(posedge clk);
			cal_done <= 1'b1;
			cal_value <= 24'h5a5a50 + 24'(m);
			@(posedge clk);
			cal_done <= 1'b0;
			wait_rdy(1'b0);
			host_u.frame((m == 3) ? 8'h78 : 8'h68, 24, 24'h0, sd);
			chk("cal coefficient", 24'h5a5a50 + 24'(m), sd);
		end
		// Pin reset returns the serial registers to their reset state
		host_u.frame(8'h10, 8, 24'h28, sd);
		chk("gain before reset", 8'h20, gain_factor);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk("gain in reset", 8'h01, gain_factor);
		chk("ready in reset", 1, result_ready_n);
		reset_n <= 1'b1;
		summarize();
	end
	// Watchdog
	initial begin
		#400us;
		failures++;
		summarize();
	end
endmodule

// >>> src/adc_port.sv
// Converter host port: serial register access, data-ready, master clock out, result FIFO
//
// Contract
// - Drive data-ready low when a fresh result sits in the data register.
// - Raise data-ready at once after a full data word has been read.
// - Unread result: raise data-ready 500 master clocks before the next update.
// - Drive data-ready low again after the data register is loaded.
// - Data-ready low also signals a finished calibration.
// - Master clock output is an inverted copy of the master clock input.
// - Master clock output stops when the clock-out-disable bit is set.
// - Chip select is active low; serial transfers only while it is low.
// - Reset pin is active low and holds the logic in reset.
// - Each result is a 16-bit word sent over the serial port.
// - Host programs gain, polarity and update rate by serial writes.
// - Gain is selectable from 1 to 128.
// - Self calibration and system calibration modes are supported.
// - Data shifts in on the input pin, out on the output pin, host clocked.
// - Seven serial registers: communication, setting, clock, data, test, two calibration.
// - Register select 000 addresses the communication register.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps

module result_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Fill side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Drain side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	// Fill level
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic in_ready_q;
	wire push = in_valid & in_ready_q;
	wire pop = out_valid & out_ready;

	// Level bookkeeping
	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + CW'(1);
		end else if (pop && !push) begin
			cnt_d = cnt_q - CW'(1);
		end
	end

	assign in_ready = in_ready_q;
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign level = cnt_q;

	// Pointers and registered full flag
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			in_ready_q <= 1'b1;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
			end
			cnt_q <= cnt_d;
			in_ready_q <= (cnt_d != CW'(DEPTH));
		end
	end

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
endmodule

module adc_port #(
	parameter int HOLD_COUNT = adc_port_pkg::HOLD_MCLK,
	parameter int DEPTH = adc_port_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register bus
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Device pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	output logic result_ready_n,
	input wire logic mclk_in,
	output logic mclk_out,
	output logic mclk_out_oe,
	input wire logic reset_n,
	// Modulator results
	input wire logic [adc_port_pkg::RES_W-1:0] res_data,
	input wire logic res_valid,
	output logic res_ready,
	// Calibration engine
	output logic cal_start,
	output logic [1:0] cal_mode,
	input wire logic cal_done,
	input wire logic [23:0] cal_value,
	// Analog controls
	output logic [7:0] gain_factor,
	output logic unipolar,
	output logic [1:0] rate_sel
);
	import adc_port_pkg::*;
	localparam int HW = $clog2(HOLD_COUNT+1);
	localparam int LW = $clog2(DEPTH+1);

	// Bits per serial register
	function automatic logic [4:0] reg_bits(input logic [2:0] rs);
		case (rs)
			RS_DATA: reg_bits = W_DATA;
			RS_ZCAL, RS_FCAL: reg_bits = W_CAL;
			default: reg_bits = W_BYTE;
		endcase
	endfunction

	// Output coding of a two's complement result
	function automatic logic [15:0] code_word(input logic [15:0] raw, input logic uni);
		if (uni) begin
			code_word = raw[15] ? 16'h0000 : {raw[14:0], 1'b0};
		end else begin
			code_word = {~raw[15], raw[14:0]};
		end
	endfunction

	// Pin synchronisers, three stages so edges use settled copies
	logic [2:0] sclk_s, cs_s, din_s, mclk_s, rstn_s;
	always_ff @(posedge clk) begin
		if (srst) begin
			sclk_s <= 3'h7;
			cs_s <= 3'h7;
			din_s <= 3'h0;
			mclk_s <= 3'h0;
			rstn_s <= 3'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], sclk};
			cs_s <= {cs_s[1:0], cs_n};
			din_s <= {din_s[1:0], din};
			mclk_s <= {mclk_s[1:0], mclk_in};
			rstn_s <= {rstn_s[1:0], reset_n};
		end
	end

	// Edge and level decode
	wire rst = srst | ~rstn_s[1];
	wire cs_low = ~cs_s[1];
	wire sclk_rise = sclk_s[1] & ~sclk_s[2];
	wire sclk_fall = ~sclk_s[1] & sclk_s[2];
	wire mclk_rise = mclk_s[1] & ~mclk_s[2];

	// State
	main_state_t st_q, st_d;
	ser_state_t ser_q;
	logic [4:0] bit_cnt_q;
	logic [SHIFT_W-1:0] shift_q;
	logic dout_q, dout_oe_q, read_done_q, ready_n_q;
	logic [7:0] comm_q, setup_q, clock_q, test_q;
	logic [23:0] zcal_q, fcal_q;
	logic [15:0] data_q;
	logic [HW-1:0] hold_cnt_q;
	logic cal_start_q, mclk_out_q, mclk_oe_q, ctrl_en_q;
	logic [7:0] gain_q;
	logic [LW-1:0] fifo_level;
	logic [15:0] fifo_data;
	logic fifo_valid;

	// Serial decode
	wire [2:0] sel = comm_q[COMM_RS_LSB +: 3];
	wire [SHIFT_W-1:0] new_word = {shift_q[SHIFT_W-2:0], din_s[1]};
	wire [2:0] cmd_sel = new_word[COMM_RS_LSB +: 3];
	wire cmd_ok = ~new_word[COMM_START_BIT];
	wire cmd_rd = new_word[COMM_RD_BIT];
	wire [4:0] target = (ser_q == SER_CMD) ? W_BYTE : reg_bits(sel);
	wire phase_end = sclk_rise & ((bit_cnt_q + 5'h01) == target);
	wire comm_wr = phase_end & (ser_q == SER_CMD) & cmd_ok;
	wire reg_wr = phase_end & (ser_q == SER_WR);
	wire cal_req = reg_wr & (sel == RS_SETUP) & (new_word[SET_MODE_LSB +: 2] != MODE_NORMAL);
	wire [23:0] rd_value = (cmd_sel == RS_COMM) ? {16'h0000, new_word[7:0]} :
		(cmd_sel == RS_SETUP) ? {16'h0000, setup_q} :
		(cmd_sel == RS_CLOCK) ? {16'h0000, clock_q} :
		(cmd_sel == RS_DATA) ? {8'h00, data_q} :
		(cmd_sel == RS_TEST) ? {16'h0000, test_q} :
		(cmd_sel == RS_ZCAL) ? zcal_q :
		(cmd_sel == RS_FCAL) ? fcal_q : 24'h000000;
	wire [SHIFT_W-1:0] rd_load = rd_value << (W_CAL - reg_bits(cmd_sel));

	// Serial engine, mode 3: drive on falling, sample on rising
	always_ff @(posedge clk) begin
		if (rst || !cs_low) begin
			ser_q <= SER_CMD;
			bit_cnt_q <= '0;
			shift_q <= '0;
			dout_q <= 1'b0;
			dout_oe_q <= 1'b0;
			read_done_q <= 1'b0;
		end else begin
			dout_oe_q <= 1'b1;
			read_done_q <= phase_end & (ser_q == SER_RD) & (sel == RS_DATA);
			if (sclk_rise) begin
				shift_q <= new_word;
				bit_cnt_q <= phase_end ? 5'h00 : bit_cnt_q + 5'h01;
			end
			if (sclk_fall && ser_q == SER_RD) begin
				dout_q <= shift_q[SHIFT_W-1];
			end
			if (phase_end) begin
				case (ser_q)
					SER_CMD: begin
						if (cmd_ok && cmd_rd) begin
							ser_q <= SER_RD;
							shift_q <= rd_load;
							dout_q <= rd_load[SHIFT_W-1];
						end else if (cmd_ok && cmd_sel != RS_COMM) begin
							ser_q <= SER_WR;
						end
					end
					default: ser_q <= SER_CMD;
				endcase
			end
		end
	end

	// Serial register file and calibration results
	always_ff @(posedge clk) begin
		if (rst) begin
			comm_q <= COMM_RST;
			setup_q <= SETUP_RST;
			clock_q <= CLOCK_RST;
			test_q <= TEST_RST;
			zcal_q <= ZCAL_RST;
			fcal_q <= FCAL_RST;
		end else begin
			if (comm_wr) begin
				comm_q <= new_word[7:0];
			end
			if (reg_wr) begin
				case (sel)
					RS_SETUP: setup_q <= new_word[7:0];
					RS_CLOCK: clock_q <= new_word[7:0];
					RS_TEST: test_q <= new_word[7:0];
					RS_ZCAL: zcal_q <= new_word[23:0];
					RS_FCAL: fcal_q <= new_word[23:0];
					default: ;
				endcase
			end
			if (st_q == ST_CAL && cal_done) begin
				if (cal_mode == MODE_SYS_FULL) begin
					fcal_q <= cal_value;
				end else begin
					zcal_q <= cal_value;
				end
				setup_q[SET_MODE_LSB +: 2] <= MODE_NORMAL;
			end
		end
	end

	// Update scheduling; no update while the host has the port selected
	wire load_ok = fifo_valid & ctrl_en_q & ~cs_low;
	wire hold_done = (hold_cnt_q == HW'(HOLD_COUNT));
	wire load = ~cal_req & load_ok & ((st_q == ST_IDLE) | ((st_q == ST_HOLD) & hold_done));

	// Next state of the data-ready machine
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (cal_req) begin
					st_d = ST_CAL;
				end else if (load) begin
					st_d = ST_READY;
				end
			end
			ST_READY: begin
				if (cal_req) begin
					st_d = ST_CAL;
				end else if (read_done_q) begin
					st_d = ST_IDLE;
				end else if (load_ok && hold_done) begin
					// Unread result stands low one hold span so a host can start a read
					st_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (cal_req) begin
					st_d = ST_CAL;
				end else if (load) begin
					st_d = ST_READY;
				end
			end
			ST_CAL: begin
				if (cal_done) begin
					st_d = ST_READY;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// Data-ready machine, data register and hold counter
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= ST_IDLE;
			ready_n_q <= 1'b1;
			data_q <= '0;
			hold_cnt_q <= '0;
			cal_start_q <= 1'b0;
			cal_mode <= MODE_NORMAL;
		end else begin
			st_q <= st_d;
			ready_n_q <= (st_d != ST_READY);
			cal_start_q <= cal_req;
			if (cal_req) begin
				cal_mode <= new_word[SET_MODE_LSB +: 2];
			end
			if (load) begin
				data_q <= code_word(fifo_data, setup_q[SET_UNI_BIT]);
			end
			if (st_d != st_q || (st_q != ST_HOLD && st_q != ST_READY)) begin
				hold_cnt_q <= '0;
			end else if (mclk_rise && !hold_done) begin
				hold_cnt_q <= hold_cnt_q + HW'(1);
			end
		end
	end

	// Master clock out and analog controls
	always_ff @(posedge clk) begin
		if (rst) begin
			mclk_out_q <= 1'b0;
			mclk_oe_q <= 1'b0;
			gain_q <= 8'h01;
		end else begin
			mclk_out_q <= ~clock_q[CLK_DIS_BIT] & ~mclk_s[1];
			mclk_oe_q <= ~clock_q[CLK_DIS_BIT];
			gain_q <= 8'h01 << setup_q[SET_GAIN_LSB +: 3];
		end
	end

	result_fifo #(.WIDTH(RES_W), .DEPTH(DEPTH)) fifo_i (
		.clk(clk),
		.srst(rst),
		.in_data(res_data),
		.in_valid(res_valid),
		.in_ready(res_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(load),
		.level(fifo_level)
	);

	// Register bus decode
	wire aw_hs = awvalid & awready;
	wire w_hs = wvalid & wready;
	wire wr_go = ~awready & ~wready & ~bvalid;
	wire [7:0] wa_q;
	logic [7:0] waddr_q;
	assign wa_q = waddr_q;
	wire wr_mapped = (wa_q == OFF_STATUS) | (wa_q == OFF_CTRL) | (wa_q == OFF_DATA) | (wa_q == OFF_CONFIG);
	wire rd_mapped = (araddr == OFF_STATUS) | (araddr == OFF_CTRL) | (araddr == OFF_DATA) | (araddr == OFF_CONFIG);
	wire [31:0] status_word = (32'(ready_n_q) << STAT_RDY_BIT) | (32'(st_q) << STAT_STATE_LSB) |
		(32'(fifo_level) << STAT_LEVEL_LSB) | (32'(cs_low) << STAT_CS_BIT);
	wire [31:0] rd_word = (araddr == OFF_STATUS) ? status_word :
		(araddr == OFF_CTRL) ? (32'(ctrl_en_q) << CTRL_EN_BIT) :
		(araddr == OFF_DATA) ? {16'h0000, data_q} :
		(araddr == OFF_CONFIG) ? {8'h00, test_q, clock_q, setup_q} : 32'h00000000;
	logic [31:0] wdata_q;
	logic wstrb0_q;

	// Register bus slave
	always_ff @(posedge clk) begin
		if (srst) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
			waddr_q <= '0;
			wdata_q <= '0;
			wstrb0_q <= 1'b0;
			ctrl_en_q <= CTRL_EN_RST;
		end else begin
			if (aw_hs) begin
				awready <= 1'b0;
				waddr_q <= awaddr;
			end
			if (w_hs) begin
				wready <= 1'b0;
				wdata_q <= wdata;
				wstrb0_q <= wstrb[0];
			end
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
				if (wa_q == OFF_CTRL && wstrb0_q) begin
					ctrl_en_q <= wdata_q[CTRL_EN_BIT];
				end
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= rd_word;
				rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// Output drivers
	assign dout = dout_q;
	assign dout_oe = dout_oe_q;
	assign result_ready_n = ready_n_q;
	assign mclk_out = mclk_out_q;
	assign mclk_out_oe = mclk_oe_q;
	assign cal_start = cal_start_q;
	assign gain_factor = gain_q;
	assign unipolar = setup_q[SET_UNI_BIT];
	assign rate_sel = clock_q[CLK_RATE_LSB +: 2];

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	load_lowers_a: assert property (load |=> !result_ready_n && st_q == ST_READY)
		else $error("data-ready not low after load");
	read_raises_a: assert property (st_q == ST_READY && read_done_q && !cal_req |=> result_ready_n)
		else $error("data-ready not high after data read");
	hold_len_a: assert property (st_q == ST_HOLD && load |-> hold_cnt_q == HW'(HOLD_COUNT))
		else $error("update came before hold time");
	hold_high_a: assert property (st_q == ST_HOLD |-> result_ready_n)
		else $error("data-ready low during hold");
	cal_flag_a: assert property (st_q == ST_CAL && cal_done |=> !result_ready_n ##0 cal_mode == $past(cal_mode))
		else $error("calibration end not flagged");
	mclk_copy_a: assert property (mclk_out_oe && $stable(clock_q) |-> mclk_out == (~clock_q[CLK_DIS_BIT] & ~$past(mclk_s[1])))
		else $error("master clock out not inverted");
	clock_out_disable_off_a: assert property ($rose(clock_q[CLK_DIS_BIT]) |=> !mclk_out_oe && !mclk_out)
		else $error("master clock out still driven");
	cs_release_a: assert property (cs_s[1] |=> !dout_oe && ser_q == SER_CMD)
		else $error("serial port active while deselected");
	word_len_a: assert property (read_done_q |-> $past(bit_cnt_q) == W_DATA - 5'h01)
		else $error("data read not 16 bits");
	coding_a: assert property (load && !setup_q[SET_UNI_BIT] |=> data_q[15] != $past(fifo_data[15]))
		else $error("bipolar code not offset binary");
	gain_range_a: assert property (##1 $onehot(gain_factor))
		else $error("gain outside 1 to 128");
	pin_reset_a: assert property (@(posedge clk) disable iff (srst) !rstn_s[1] |=> result_ready_n && st_q == ST_IDLE)
		else $error("reset pin not honoured");

	hold_update_c: cover property (st_q == ST_HOLD && load);
	cal_finish_c: cover property (st_q == ST_CAL && cal_done);
	fifo_full_c: cover property (!res_ready && res_valid);
	data_read_c: cover property (read_done_q && st_q == ST_READY);
endmodule
